// [rtl/cpu_instruction_timing.sv]
//------------------------------------------------------------------------------
// Purpose: Instruction issue timing, debug control, flash byte access, data RAM
// Assumes: Fetch side offers one decoded opcode with its branch outcome
// Notes: Debug request pins are asynchronous and are synchronised here
//------------------------------------------------------------------------------
`timescale 1ns/100ps
module cpu_instruction_timing
  import insn_timing_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Instruction offer from fetch
  input wire logic op_valid,
  input wire logic [7:0] op_code,
  input wire logic [15:0] op_pc,
  input wire logic op_taken,
  output logic op_ready,
  output logic issue,
  // Current instruction cost
  output logic [1:0] exec_bytes,
  output logic [3:0] exec_cycles,
  output logic exec_busy,
  // Flash access by external move and code read
  input wire logic flash_write_enable,
  input wire logic flash_erase_enable,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic flash_wr,
  output logic flash_erase,
  output logic code_rd,
  output logic [15:0] flash_addr,
  output logic [7:0] flash_wdata,
  // Debug pins from the host
  input wire logic dbg_halt_pin,
  input wire logic dbg_run_pin,
  input wire logic dbg_step_pin,
  input wire logic bp_enable,
  input wire logic [15:0] bp_addr,
  output logic halted,
  // Data RAM, core port and debug port
  input wire logic ram_we,
  input wire logic [7:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  input wire logic dbg_mem_we,
  input wire logic [7:0] dbg_mem_addr,
  input wire logic [7:0] dbg_mem_wdata,
  output logic [7:0] ram_rdata
);
  import insn_timing_pkg::*;

  typedef struct packed {
    dbg_state_e dbg;
    logic resume;
    logic [3:0] remain;
    logic [3:0] cur_cycles;
    logic [1:0] cur_bytes;
    logic [3:0] gap;
    logic [2:0] halt_sync;
    logic [2:0] run_sync;
    logic [2:0] step_sync;
    logic flash_wr;
    logic flash_erase;
    logic code_rd;
    logic [15:0] flash_addr;
    logic [7:0] flash_wdata;
    logic [7:0] ram_rdata;
    logic [RAM_BYTES-1:0][7:0] ram;
  } state_s;

  state_s s;
  state_s next_s;

  logic [1:0] c_bytes;
  logic [3:0] c_cycles;
  logic c_cond;
  logic c_ext_wr;
  logic c_ext_rd;
  logic c_code_rd;
  logic [3:0] total;
  logic bp_hit;
  logic halt_edge;
  logic run_edge;
  logic step_edge;
  logic [7:0] port_addr;

  //----------------------------------------------------------------------------
  // Decode
  //----------------------------------------------------------------------------
  // Opcode cost lookup
  opcode_cost u_cost (
    .opcode(op_code),
    .bytes(c_bytes),
    .cycles(c_cycles),
    .is_cond(c_cond),
    .is_ext_write(c_ext_wr),
    .is_ext_read(c_ext_rd),
    .is_code_read(c_code_rd)
  );

  //----------------------------------------------------------------------------
  // Issue control
  //----------------------------------------------------------------------------
  // Taken branch adds one clock to the base count
  assign total = c_cycles + {3'h0, c_cond & op_taken};
  assign halt_edge = s.halt_sync[1] & ~s.halt_sync[2];
  assign run_edge = s.run_sync[1] & ~s.run_sync[2];
  assign step_edge = s.step_sync[1] & ~s.step_sync[2];
  assign bp_hit = bp_enable && op_valid && (op_pc == bp_addr) && !s.resume &&
                  (s.remain == 4'h0) && (s.dbg != DBG_HALT);
  // Ready every clock while idle and not halted or at a breakpoint, so one-clock opcodes issue back to back
  assign op_ready = (s.remain == 4'h0) && (s.dbg != DBG_HALT) && !bp_hit;
  assign issue = op_valid && op_ready;
  assign exec_busy = (s.remain != 4'h0);
  assign port_addr = (s.dbg == DBG_HALT) ? dbg_mem_addr : ram_addr;

  //----------------------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------------------
  // Counting, debug control, flash strobes and RAM in one pass
  always_comb
  begin
    next_s = s;
    next_s.halt_sync = {s.halt_sync[1:0], dbg_halt_pin};
    next_s.run_sync = {s.run_sync[1:0], dbg_run_pin};
    next_s.step_sync = {s.step_sync[1:0], dbg_step_pin};
    next_s.flash_wr = 1'b0;
    next_s.flash_erase = 1'b0;
    next_s.code_rd = 1'b0;
    next_s.gap = (s.gap == GAP_MAX) ? GAP_MAX : s.gap + 4'h1;
    if (s.remain != 4'h0)
      next_s.remain = s.remain - 4'h1;
    if (issue)
    begin
      next_s.remain = total - 4'h1;
      next_s.cur_cycles = total;
      next_s.cur_bytes = c_bytes;
      next_s.gap = 4'h1;
      next_s.resume = 1'b0;
      if (c_ext_wr && flash_write_enable)
      begin
        next_s.flash_wr = ~flash_erase_enable;
        next_s.flash_erase = flash_erase_enable;
      end
      next_s.code_rd = c_code_rd | (c_ext_rd & flash_write_enable);
      if (c_code_rd || ((c_ext_wr || c_ext_rd) && flash_write_enable))
      begin
        next_s.flash_addr = mem_addr;
        next_s.flash_wdata = mem_wdata;
      end
    end
    // Debug control, halt waits for no bus but stops further issue
    case (s.dbg)
      DBG_RUN:
      begin
        if (halt_edge || bp_hit)
          next_s.dbg = DBG_HALT;
      end
      DBG_STEP:
      begin
        if (issue || halt_edge || bp_hit)
          next_s.dbg = DBG_HALT;
      end
      DBG_HALT:
      begin
        if (step_edge)
        begin
          next_s.dbg = DBG_STEP;
          next_s.resume = 1'b1;
        end
        else if (run_edge)
        begin
          next_s.dbg = DBG_RUN;
          next_s.resume = 1'b1;
        end
      end
      default:
        next_s.dbg = DBG_HALT;
    endcase
    // RAM: debug port owns it while halted, costs the program nothing
    if ((s.dbg == DBG_HALT) ? dbg_mem_we : ram_we)
      next_s.ram[port_addr] = (s.dbg == DBG_HALT) ? dbg_mem_wdata : ram_wdata;
    next_s.ram_rdata = s.ram[port_addr];
    if (!rst_n)
    begin
      next_s = '0;
      next_s.dbg = DBG_RUN;
      next_s.gap = GAP_MAX;
    end
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    s <= next_s;
  end

  //----------------------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------------------
  assign exec_bytes = s.cur_bytes;
  assign exec_cycles = s.cur_cycles;
  assign flash_wr = s.flash_wr;
  assign flash_erase = s.flash_erase;
  assign code_rd = s.code_rd;
  assign flash_addr = s.flash_addr;
  assign flash_wdata = s.flash_wdata;
  assign halted = (s.dbg == DBG_HALT);
  assign ram_rdata = s.ram_rdata;

  //----------------------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  hold_off_a: assert property (issue |-> s.gap >= s.cur_cycles)
    else $error("next instruction issued before current completed");
  ready_again_a: assert property (issue && op_code == OP_DIV |=> !op_ready [*7])
    else $error("issue slot opened inside an eight clock instruction");
  max_eight_a: assert property (issue |-> total <= CYC_MAX && total != 4'h0)
    else $error("instruction cost out of range");
  branch_extra_a: assert property (issue && c_cond && op_taken |=>
    exec_cycles == $past(c_cycles) + 4'h1)
    else $error("taken branch not exactly one clock longer");
  arith_reg_a: assert property (issue && op_code == 8'h28 |=>
    exec_cycles == CYC_ONE && exec_bytes == BYTES_ONE)
    else $error("register arithmetic not one byte one clock");
  arith_direct_a: assert property (issue && op_code == 8'h35 |=>
    exec_cycles == CYC_TWO && exec_bytes == BYTES_TWO)
    else $error("direct arithmetic not two bytes two clocks");
  arith_ind_a: assert property (issue && op_code == 8'h96 |=>
    exec_cycles == CYC_TWO && exec_bytes == BYTES_ONE)
    else $error("indirect arithmetic not one byte two clocks");
  arith_imm_a: assert property (issue && op_code == 8'h24 |=>
    exec_cycles == CYC_TWO && exec_bytes == BYTES_TWO)
    else $error("immediate arithmetic not two bytes two clocks");
  halt_blocks_a: assert property (halted |-> !issue)
    else $error("issue while halted");
  flash_write_a: assert property (issue && c_ext_wr && flash_write_enable &&
    !flash_erase_enable |=> flash_wr && flash_addr == $past(mem_addr))
    else $error("flash write strobe missing");
  ram_keep_a: assert property (!halted && ram_we ##1 !halted && !ram_we &&
    ram_addr == $past(ram_addr) |=> ram_rdata == $past(ram_wdata, 2))
    else $error("data RAM lost a written byte");

  back_to_back_c: cover property (issue ##1 issue ##1 issue);
  branch_taken_c: cover property (issue && c_cond && op_taken);
  step_done_c: cover property (s.dbg == DBG_STEP && issue ##1 halted);
  flash_erase_c: cover property (flash_erase);
endmodule

// [rtl/insn_timing_pkg.sv]
//------------------------------------------------------------------------------
// Purpose: Shared constants for the instruction timing and issue logic
// Assumes: Single core clock, byte-wide opcodes, 16-bit code addresses
// Notes: Cycle figures are single core clocks, never grouped machine cycles
//------------------------------------------------------------------------------
package insn_timing_pkg;

  //----------------------------------------------------------------------------
  // Clock and throughput
  //----------------------------------------------------------------------------
  localparam int CORE_CLK_MHZ = 125;
  localparam int PEAK_CLK_MHZ = 50;
  localparam int INSN_PER_CLK = 1;
  localparam int INSN_TOTAL = 109;
  localparam int INSN_ONE_CLK = 26;
  localparam int INSN_TWO_CLK = 50;

  //----------------------------------------------------------------------------
  // Cycle and byte counts
  //----------------------------------------------------------------------------
  localparam logic [3:0] CYC_ONE = 4'h1;
  localparam logic [3:0] CYC_TWO = 4'h2;
  localparam logic [3:0] CYC_THREE = 4'h3;
  localparam logic [3:0] CYC_FOUR = 4'h4;
  localparam logic [3:0] CYC_MAX = 4'h8;
  localparam logic [3:0] GAP_MAX = 4'hf;
  localparam logic [1:0] BYTES_ONE = 2'h1;
  localparam logic [1:0] BYTES_TWO = 2'h2;
  localparam logic [1:0] BYTES_THREE = 2'h3;

  //----------------------------------------------------------------------------
  // Opcode groups and single opcodes
  //----------------------------------------------------------------------------
  localparam logic [3:0] GRP_ADD = 4'h2;
  localparam logic [3:0] GRP_ADD_WITH_CARRY = 4'h3;
  localparam logic [3:0] GRP_SUBTRACT_WITH_BORROW = 4'h9;
  localparam logic [3:0] MODE_IMM = 4'h4;
  localparam logic [3:0] MODE_DIRECT = 4'h5;
  localparam logic [3:0] MODE_IND0 = 4'h6;
  localparam logic [3:0] MODE_IND1 = 4'h7;
  localparam logic [3:0] MODE_REG0 = 4'h8;
  localparam logic [7:0] OP_MUL = 8'ha4;
  localparam logic [7:0] OP_DIV = 8'h84;
  localparam logic [7:0] OP_CODE_READ_DPTR = 8'h93;
  localparam logic [7:0] OP_CODE_READ_PC = 8'h83;
  localparam logic [7:0] OP_EXT_RD_DPTR = 8'he0;
  localparam logic [7:0] OP_EXT_RD_R0 = 8'he2;
  localparam logic [7:0] OP_EXT_RD_R1 = 8'he3;
  localparam logic [7:0] OP_EXT_WR_DPTR = 8'hf0;
  localparam logic [7:0] OP_EXT_WR_R0 = 8'hf2;
  localparam logic [7:0] OP_EXT_WR_R1 = 8'hf3;
  localparam logic [7:0] OP_JBC = 8'h10;
  localparam logic [7:0] OP_JB = 8'h20;
  localparam logic [7:0] OP_JNB = 8'h30;
  localparam logic [7:0] OP_JC = 8'h40;
  localparam logic [7:0] OP_JNC = 8'h50;
  localparam logic [7:0] OP_JZ = 8'h60;
  localparam logic [7:0] OP_JNZ = 8'h70;
  localparam logic [7:0] OP_DJNZ_DIR = 8'hd5;
  localparam logic [3:0] GRP_CJNE = 4'hb;
  localparam logic [3:0] GRP_DJNZ = 4'hd;

  //----------------------------------------------------------------------------
  // Debug control states, Gray along run, step, halt
  //----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    DBG_RUN = 2'h0,
    DBG_STEP = 2'h1,
    DBG_HALT = 2'h3
  } dbg_state_e;

  localparam int RAM_BYTES = 256;
endpackage

// [rtl/opcode_cost.sv]
//------------------------------------------------------------------------------
// Purpose: Opcode to byte length, base clock count and class flags
// Assumes: Purely combinational, opcode stable while read
// Notes: Base count is the not-taken time of conditional branches
//------------------------------------------------------------------------------
`timescale 1ns/100ps
module opcode_cost
  import insn_timing_pkg::*;
(
  // Opcode in
  input wire logic [7:0] opcode,
  // Cost out
  output logic [1:0] bytes,
  output logic [3:0] cycles,
  // Class flags
  output logic is_cond,
  output logic is_ext_write,
  output logic is_ext_read,
  output logic is_code_read
);

  logic [3:0] hi;
  logic [3:0] lo;
  logic arith;

  assign hi = opcode[7:4];
  assign lo = opcode[3:0];
  assign arith = (hi == GRP_ADD) || (hi == GRP_ADD_WITH_CARRY) ||
                 (hi == GRP_SUBTRACT_WITH_BORROW);

  // Cost lookup, most opcodes take one clock per program byte
  always_comb
  begin
    bytes = BYTES_ONE;
    cycles = CYC_ONE;
    is_cond = 1'b0;
    is_ext_write = 1'b0;
    is_ext_read = 1'b0;
    is_code_read = 1'b0;
    if ((lo == MODE_IMM) || (lo == MODE_DIRECT))
    begin
      bytes = BYTES_TWO;
      cycles = CYC_TWO;
    end
    if (((lo == MODE_IND0) || (lo == MODE_IND1)) && (hi >= GRP_ADD))
      cycles = CYC_TWO;
    if (arith)
    begin
      if (lo >= MODE_REG0)
      begin
        bytes = BYTES_ONE;
        cycles = CYC_ONE;
      end
      else if (lo == MODE_DIRECT)
      begin
        bytes = BYTES_TWO;
        cycles = CYC_TWO;
      end
      else if ((lo == MODE_IND0) || (lo == MODE_IND1))
      begin
        bytes = BYTES_ONE;
        cycles = CYC_TWO;
      end
      else if (lo == MODE_IMM)
      begin
        bytes = BYTES_TWO;
        cycles = CYC_TWO;
      end
    end
    case (opcode)
      OP_MUL:
      begin
        bytes = BYTES_ONE;
        cycles = CYC_FOUR;
      end
      OP_DIV:
      begin
        bytes = BYTES_ONE;
        cycles = CYC_MAX;
      end
      OP_CODE_READ_DPTR, OP_CODE_READ_PC:
      begin
        bytes = BYTES_ONE;
        cycles = CYC_THREE;
        is_code_read = 1'b1;
      end
      OP_EXT_RD_DPTR, OP_EXT_RD_R0, OP_EXT_RD_R1:
      begin
        bytes = BYTES_ONE;
        cycles = CYC_THREE;
        is_ext_read = 1'b1;
      end
      OP_EXT_WR_DPTR, OP_EXT_WR_R0, OP_EXT_WR_R1:
      begin
        bytes = BYTES_ONE;
        cycles = CYC_THREE;
        is_ext_write = 1'b1;
      end
      OP_JC, OP_JNC, OP_JZ, OP_JNZ:
      begin
        bytes = BYTES_TWO;
        cycles = CYC_TWO;
        is_cond = 1'b1;
      end
      OP_JBC, OP_JB, OP_JNB, OP_DJNZ_DIR:
      begin
        bytes = BYTES_THREE;
        cycles = CYC_THREE;
        is_cond = 1'b1;
      end
      default:
      begin
        if ((hi == GRP_CJNE) && (lo >= MODE_IMM))
        begin
          bytes = BYTES_THREE;
          cycles = CYC_THREE;
          is_cond = 1'b1;
        end
        else if ((hi == GRP_DJNZ) && (lo >= MODE_REG0))
        begin
          bytes = BYTES_TWO;
          cycles = CYC_TWO;
          is_cond = 1'b1;
        end
      end
    endcase
  end
endmodule

// [verif/fetch_source.sv]
//------------------------------------------------------------------------------
// Purpose: Fetch side model offering opcodes to the issue port
// Assumes: Offers change after the falling edge and hold until taken
// Notes: Idle offer lines toggle each cycle so stale values never look valid
//------------------------------------------------------------------------------
`timescale 1ns/100ps
module fetch_source
(
  // Clock
  input wire logic core_clk,
  // Offer handshake
  input wire logic issue,
  output logic op_valid,
  output logic [7:0] op_code,
  output logic [15:0] op_pc,
  output logic op_taken
);
  typedef struct packed {logic [7:0] code; logic [15:0] pc; logic taken; logic [3:0] gap;} offer_s;
  offer_s fifo[$];
  offer_s cur;
  logic have = 1'b0;
  logic took = 1'b0;
  int wait_cnt = 0;

  // Quiet lines at start
  initial
  begin
    op_valid = 1'b0;
    op_code = 8'h00;
    op_pc = 16'h0000;
    op_taken = 1'b0;
  end

  // Queue one offer with its idle gap in cycles
  task automatic push(input offer_s o);
    fifo.push_back(o);
  endtask

  // Nothing queued, waiting or offered
  function automatic logic idle();
    return (fifo.size() == 0) && !have && !op_valid;
  endfunction

  // Handshake seen shortly before the taking edge
  always
  begin
    @(negedge core_clk);
    #3;
    took = issue;
  end

  // Hold an offer until taken, then move on
  always @(negedge core_clk)
  begin
    logic nv;
    nv = op_valid && !took;
    if (!nv && !have && fifo.size() > 0)
    begin
      cur = fifo.pop_front();
      have = 1'b1;
      wait_cnt = cur.gap;
    end
    if (!nv && have && wait_cnt == 0)
    begin
      nv = 1'b1;
      have = 1'b0;
      op_code <= cur.code;
      op_pc <= cur.pc;
      op_taken <= cur.taken;
    end
    else if (!nv)
    begin
      if (wait_cnt > 0) wait_cnt--;
      op_code <= ~op_code;
      op_pc <= ~op_pc;
      op_taken <= ~op_taken;
    end
    op_valid <= nv;
  end
endmodule

// [verif/tb.sv]
//------------------------------------------------------------------------------
// Purpose: Self-checking bench for instruction issue timing, flash, debug, RAM
// Assumes: Inputs change on the falling edge, outputs sampled 1 ns before rising
// Notes: Expected costs are queued by the driver and popped at each issue
//------------------------------------------------------------------------------
`timescale 1ns/100ps
module tb;
  import insn_timing_pkg::*;
  typedef struct packed {logic [1:0] nb; logic [3:0] nc; logic [1:0] rel;} note_s;
  typedef struct packed {logic [2:0] k; logic [15:0] a; logic [7:0] d;} fl_s;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic op_valid, op_taken, op_ready, issue, exec_busy, halted;
  logic [7:0] op_code;
  logic [15:0] op_pc;
  logic [1:0] exec_bytes;
  logic [3:0] exec_cycles;
  logic flash_write_enable, flash_erase_enable, flash_wr, flash_erase, code_rd;
  logic [15:0] mem_addr, flash_addr, bp_addr;
  logic [7:0] mem_wdata, flash_wdata, ram_addr, ram_wdata, dbg_mem_addr, dbg_mem_wdata, ram_rdata;
  logic [2:0] dbg_pins;
  logic bp_enable, ram_we, dbg_mem_we;
  note_s nq[$];
  fl_s fq[$];
  note_s cur;
  fl_s f;
  logic pend = 1'b0;
  logic bon = 1'b0;
  logic [3:0] base_seen, xc, n, g;
  logic [31:0] rnd;
  logic [7:0] fops [8] = '{8'hf0, 8'hf2, 8'hf3, 8'he0, 8'he2, 8'he3, 8'h83, 8'h93};
  logic [7:0] bops [8] = '{OP_JBC, OP_JB, OP_JNB, OP_JC, OP_JNC, OP_JZ, OP_JNZ, OP_DJNZ_DIR};
  int blen = 0;
  int issue_cnt = 0;
  int error_cnt = 0;
  int total_checks = 0;
  int seed, i, n0;

  always #4 core_clk = ~core_clk;

  fetch_source u_fetch (.core_clk(core_clk), .issue(issue), .op_valid(op_valid),
    .op_code(op_code), .op_pc(op_pc), .op_taken(op_taken));

  cpu_instruction_timing u_dut (.core_clk(core_clk), .rst_n(rst_n), .op_valid(op_valid),
    .op_code(op_code), .op_pc(op_pc), .op_taken(op_taken), .op_ready(op_ready),
    .issue(issue), .exec_bytes(exec_bytes), .exec_cycles(exec_cycles),
    .exec_busy(exec_busy), .flash_write_enable(flash_write_enable),
    .flash_erase_enable(flash_erase_enable), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .flash_wr(flash_wr), .flash_erase(flash_erase), .code_rd(code_rd),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata), .dbg_halt_pin(dbg_pins[0]),
    .dbg_run_pin(dbg_pins[1]), .dbg_step_pin(dbg_pins[2]), .bp_enable(bp_enable),
    .bp_addr(bp_addr), .halted(halted), .ram_we(ram_we), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .dbg_mem_we(dbg_mem_we), .dbg_mem_addr(dbg_mem_addr),
    .dbg_mem_wdata(dbg_mem_wdata), .ram_rdata(ram_rdata));

  //----------------------------------------------------------------------------
  // Shared tasks
  //----------------------------------------------------------------------------
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Counts, verdict and stop
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Queue an offer and its expected cost
  task automatic op(input logic [7:0] c, input logic [15:0] p, input logic t,
    input logic [3:0] gp, input logic [1:0] nb, input logic [3:0] nc, input logic [1:0] rel);
    u_fetch.push({c, p, t, gp});
    nq.push_back({nb, nc, rel});
  endtask

  // Wait until every offer is issued and finished
  task automatic drain(input string name);
    int k;
    for (k = 0; k < 300 && !(u_fetch.idle() && nq.size() == 0 && exec_busy === 1'b0); k++)
      @(negedge core_clk);
    check(k < 300, 1'b1);
    repeat (2) @(negedge core_clk);
    $display("test %s done", name);
  endtask

  // Debug pin pulse, wide enough for the synchroniser
  task automatic pin(input int k);
    @(negedge core_clk);
    dbg_pins[k] = 1'b1;
    repeat (4) @(negedge core_clk);
    dbg_pins[k] = 1'b0;
    repeat (6) @(negedge core_clk);
  endtask

  // One RAM access on core port or debug port, then read back
  task automatic ram_rw(input logic dp, input logic we, input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    if (dp) {dbg_mem_we, dbg_mem_addr, dbg_mem_wdata} = {we, a, d};
    else {ram_we, ram_addr, ram_wdata} = {we, a, d};
    @(negedge core_clk);
    dbg_mem_we = 1'b0;
    ram_we = 1'b0;
    @(negedge core_clk);
  endtask

  //----------------------------------------------------------------------------
  // Result monitor
  //----------------------------------------------------------------------------
  always
  begin
    @(negedge core_clk);
    #3;
    if (pend)
    begin
      if (cur.rel == 2'h1) base_seen = exec_cycles;
      else if (cur.rel == 2'h2) check(exec_cycles, base_seen + 4'h1);
      else check({exec_bytes, exec_cycles}, cur[7:2]);
      if (cur.rel == 2'h0) check(exec_cycles <= CYC_MAX, 1'b1);
      xc = exec_cycles;
      blen = 0;
      pend = 1'b0;
      bon = 1'b1;
    end
    if (bon && exec_busy === 1'b1)
    begin
      blen++;
      check(op_ready, 1'b0);
    end
    else if (bon)
    begin
      check(blen + 1, xc);
      check(op_ready | halted | bp_enable, 1'b1);
      bon = 1'b0;
    end
    if (issue === 1'b1)
    begin
      check(exec_busy, 1'b0);
      if (nq.size() == 0) check(1'b1, 1'b0);
      else cur = nq.pop_front();
      pend = (nq.size() >= 0);
      issue_cnt++;
    end
    if ((flash_wr | flash_erase | code_rd) === 1'b1)
    begin
      if (fq.size() == 0) check(1'b1, 1'b0);
      else f = fq.pop_front();
      check({flash_wr, flash_erase, code_rd, flash_addr}, {f.k, f.a});
      if (f.k != 3'b001) check(flash_wdata, f.d);
    end
  end

  // Watchdog, well past the expected run
  initial
  begin
    #400000;
    error_cnt++;
    end_sim();
  end

  //----------------------------------------------------------------------------
  // Scenarios
  //----------------------------------------------------------------------------
  initial
  begin
    seed = 89;
    {flash_write_enable, flash_erase_enable, mem_addr, mem_wdata, dbg_pins} = '0;
    {bp_enable, bp_addr, ram_we, ram_addr, ram_wdata} = '0;
    {dbg_mem_we, dbg_mem_addr, dbg_mem_wdata} = '0;
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    ram_rw(1'b0, 1'b0, 8'h00, 8'h00);
    check(ram_rdata, 8'h00);
    // Arithmetic in every mode, random spacing
    for (i = 0; i < 36; i++)
    begin
      g = (i < 12) ? GRP_ADD : ((i < 24) ? GRP_ADD_WITH_CARRY : GRP_SUBTRACT_WITH_BORROW);
      n = 4'(i % 12 + 4);
      rnd = $random(seed);
      op({g, n}, rnd[31:16], 1'b0, {2'h0, rnd[1:0]},
        ((n >= MODE_REG0) || (n >= MODE_IND0)) ? BYTES_ONE : BYTES_TWO,
        (n >= MODE_REG0) ? CYC_ONE : CYC_TWO, 2'h0);
    end
    op(OP_MUL, 16'h0010, 1'b0, 4'h0, BYTES_ONE, CYC_FOUR, 2'h0);
    op(OP_DIV, 16'h0011, 1'b0, 4'h0, BYTES_ONE, CYC_MAX, 2'h0);
    drain("arith");
    // Eight branch opcodes from bops, each not taken then taken
    for (i = 0; i < 8; i++)
    begin
      op(bops[i], 16'h0200, 1'b0, 4'h0, 2'h0, 4'h0, 2'h1);
      op(bops[i], 16'h0202, 1'b1, 4'h1, 2'h0, 4'h0, 2'h2);
    end
    drain("branch");
    // Flash byte writes, erases and reads
    flash_write_enable = 1'b1;
    for (i = 0; i < 8; i++)
    begin
      rnd = $random(seed);
      {mem_addr, mem_wdata} = rnd[23:0];
      flash_erase_enable = i[0];
      fq.push_back({(i < 3) ? (i[0] ? 3'b010 : 3'b100) : 3'b001, rnd[23:8], rnd[7:0]});
      op(fops[i], 16'h0300, 1'b0, 4'h0, BYTES_ONE, CYC_THREE, 2'h0);
      drain("flash");
    end
    flash_write_enable = 1'b0;
    op(8'hf0, 16'h0310, 1'b0, 4'h0, BYTES_ONE, CYC_THREE, 2'h0);
    op(8'he0, 16'h0311, 1'b0, 4'h0, BYTES_ONE, CYC_THREE, 2'h0);
    drain("flash off");
    check(fq.size(), 0);
    // Halt, refuse, single step, debug RAM access, run
    ram_rw(1'b0, 1'b1, 8'hff, 8'h3c);
    check(ram_rdata, 8'h3c);
    pin(0);
    check(halted, 1'b1);
    n0 = issue_cnt;
    op(8'h28, 16'h0400, 1'b0, 4'h0, BYTES_ONE, CYC_ONE, 2'h0);
    op(8'h29, 16'h0401, 1'b0, 4'h0, BYTES_ONE, CYC_ONE, 2'h0);
    repeat (5) @(negedge core_clk);
    check(issue_cnt, n0);
    pin(2);
    check({halted, 16'(issue_cnt)}, {1'b1, 16'(n0 + 1)});
    ram_rw(1'b0, 1'b1, 8'hff, 8'hc3);
    ram_rw(1'b1, 1'b0, 8'hff, 8'h00);
    check(ram_rdata, 8'h3c);
    ram_rw(1'b1, 1'b1, 8'hff, 8'h96);
    check(ram_rdata, 8'h96);
    pin(1);
    drain("step");
    check({halted, 16'(issue_cnt)}, {1'b0, 16'(n0 + 2)});
    ram_rw(1'b0, 1'b0, 8'hff, 8'h00);
    check(ram_rdata, 8'h96);
    // Breakpoint stops before the matching opcode
    bp_enable = 1'b1;
    bp_addr = 16'h0123;
    n0 = issue_cnt;
    op(8'h24, 16'h0123, 1'b0, 4'h0, BYTES_TWO, CYC_TWO, 2'h0);
    repeat (6) @(negedge core_clk);
    check({halted, 16'(issue_cnt)}, {1'b1, 16'(n0)});
    pin(1);
    drain("breakpoint");
    check(issue_cnt, n0 + 1);
    end_sim();
  end
endmodule
